// ==== nand_ctrl_pkg.sv ====
// Constants, types and helpers shared by the flash sequencer.
package nand_ctrl_pkg;
	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int TMR_W = 4; // Strobe timer width
	localparam int CNT_W = 12; // Byte counter width
	localparam int ECC_W = 48; // Six parity bytes
	// ----------------------------------------
	// Counts and values
	// ----------------------------------------
	localparam logic [11:0] ECC_BYTES = 12'h006; // Parity bytes per page
	localparam logic [7:0] PAD_BYTE = 8'hFF; // Spare fill on writes
	localparam logic [7:0] BYTE_RST = 8'h00; // Data register reset
	localparam logic [1:0] CS_RST = 2'h0; // Chip index at reset
	localparam logic [47:0] ECC_RST = 48'h000000000000; // Parity reset
	localparam logic [47:0] ECC_POLY = 48'h1000000000B7; // Symbol code divisor
	localparam logic [3:0] CEN_IDLE = 4'hF; // All chips deselected
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [2:0] {OP_CMD, OP_ADDR, OP_PWRITE, OP_PREAD, OP_DWRITE,
		OP_DREAD} op_t;
	typedef enum logic [2:0] {PH_CMD, PH_ADDR, PH_DATA, PH_ECC, PH_SPARE,
		PH_DIRECT} phase_t;
	typedef enum logic [2:0] {ST_IDLE, ST_WAIT, ST_SETUP, ST_PULSE,
		ST_HOLD} state_t;
	// ----------------------------------------
	// Parity update over one byte
	// ----------------------------------------
	function automatic logic [47:0] ecc_step(input logic [47:0] e, input logic [7:0] b,
		input logic [11:0] idx, input logic rs);
		logic [47:0] s;
		logic fb;
		s = e;
		if (rs) begin
			// Symbol code: byte-serial division, MSB first
			for (int k = 7; k >= 0; k--) begin
				fb = s[47] ^ b[k];
				s = {s[46:0], 1'b0};
				if (fb) begin
					s = s ^ ECC_POLY;
				end
			end
		end else begin
			// Column parity plus line parity pair
			s[7:0] = e[7:0] ^ b;
			if (^b) begin
				s[19:8] = e[19:8] ^ idx;
				s[31:20] = e[31:20] ^ ~idx;
			end
		end
		return s;
	endfunction
endpackage

// ==== nand_flash_interface_ctrl.sv ====
// Parallel flash sequencer: strobes, phases, parity and data staging.
`timescale 1ns/1ps
module nand_flash_interface_ctrl
	import nand_ctrl_pkg::*;
(
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic clk_en,
	input wire logic kick, // Start one phase sequence
	input wire op_t op, // What the kick does
	input wire logic [7:0] cmd_byte, // Command, address or direct byte
	input wire logic [1:0] cs_sel, // Chip index
	input wire logic cs_keep, // Hold chip selected when idle
	input wire logic [11:0] page_size, // Data bytes per page
	input wire logic [11:0] spare_size, // Spare bytes after parity
	input wire logic ecc_ena, // Append/check parity
	input wire logic ecc_rs, // Symbol code instead of parity
	input wire logic [3:0] t_setup, // Cycles before strobe, minus one
	input wire logic [3:0] t_pulse, // Strobe low cycles, minus one
	input wire logic [3:0] t_hold, // Cycles after strobe, minus one
	output logic busy,
	output logic done, // One-cycle completion pulse
	output logic ecc_err,
	output logic [47:0] ecc_syndrome,
	output logic [7:0] dir_rdata,
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	output logic tx_ready,
	output logic [7:0] rx_data,
	output logic rx_valid,
	input wire logic rx_ready,
	input wire logic [7:0] nand_d_in,
	output logic [7:0] nand_d_out,
	output logic nand_d_oe,
	output logic cle,
	output logic ale,
	output logic [3:0] cen_n,
	output logic ren_n,
	output logic wen_n
);
	// ----------------------------------------
	// Sequencer state
	// ----------------------------------------
	state_t st_r, st_nxt; // Strobe state
	phase_t ph_r, ph_nxt; // Current phase
	logic [TMR_W-1:0] tmr_r, tmr_nxt; // Strobe timer
	logic [CNT_W-1:0] cnt_r, cnt_nxt; // Byte index in phase
	logic wr_r, wr_nxt; // Bus driven this transfer
	logic busy_r, busy_nxt;
	logic done_r, done_nxt;
	logic [1:0] cs_r, cs_nxt; // Selected chip
	logic ecc_r, ecc_nxt; // Parity on for this transfer
	logic rs_r, rs_nxt; // Code choice for this transfer
	logic [11:0] page_r, page_nxt; // Latched page length
	logic [11:0] spare_r, spare_nxt; // Latched spare length
	logic [7:0] byte_r, byte_nxt; // Software byte
	logic [7:0] dout_r, dout_nxt; // Byte on the bus
	logic [7:0] drd_r, drd_nxt; // Direct read result
	// ----------------------------------------
	// Parity state
	// ----------------------------------------
	logic [47:0] calc_r, calc_nxt; // Running parity
	logic [47:0] stored_r, stored_nxt; // Parity read back
	logic [47:0] syn_r, syn_nxt; // Difference after read
	logic err_r, err_nxt;
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	logic strobe_end; // Last cycle of the low strobe
	logic byte_end; // Last cycle of hold
	logic last; // Final byte of the phase
	logic fin; // Sequence ends this cycle
	logic rx_push, rx_space; // Buffer fill side
	logic [11:0] len; // Bytes in current phase

	// Phase length: data uses page, parity fixed, spare uses spare, others one
	function automatic logic [11:0] phase_len(input phase_t p, input logic [11:0] pg,
		input logic [11:0] sp);
		case (p)
			PH_DATA: phase_len = pg;
			PH_ECC: phase_len = ECC_BYTES;
			PH_SPARE: phase_len = sp;
			default: phase_len = 12'h001;
		endcase
	endfunction

	assign strobe_end = (st_r == ST_PULSE) && (tmr_r == '0);
	assign byte_end = (st_r == ST_HOLD) && (tmr_r == '0);
	assign len = phase_len(ph_r, page_r, spare_r);
	assign last = (cnt_r == len - 12'h001) || (len == '0);

	// ----------------------------------------
	// Data staging
	// ----------------------------------------
	// Page bytes leave through the buffer so a stalled reader loses nothing
	assign rx_push = clk_en && strobe_end && !wr_r && (ph_r == PH_DATA);
	rx_skid_buf #(.WIDTH(8), .DEPTH(2)) u_rx_buf (
		.ref_clk(ref_clk),
		.srst(srst),
		.clk_en(clk_en),
		.in_data(nand_d_in),
		.in_valid(rx_push),
		.in_ready(rx_space),
		.out_data(rx_data),
		.out_valid(rx_valid),
		.out_ready(rx_ready)
	);
	// Take a write byte only when the strobe engine can start it
	assign tx_ready = clk_en && (st_r == ST_WAIT) && wr_r && (ph_r == PH_DATA);

	// ----------------------------------------
	// Sequencer next state
	// ----------------------------------------
	always_comb begin
		st_nxt = st_r;
		ph_nxt = ph_r;
		tmr_nxt = tmr_r;
		cnt_nxt = cnt_r;
		wr_nxt = wr_r;
		busy_nxt = busy_r;
		done_nxt = 1'b0;
		cs_nxt = cs_r;
		ecc_nxt = ecc_r;
		rs_nxt = rs_r;
		page_nxt = page_r;
		spare_nxt = spare_r;
		byte_nxt = byte_r;
		dout_nxt = dout_r;
		drd_nxt = drd_r;
		fin = 1'b0;
		case (st_r)
			ST_IDLE: begin
				// Software owns the order of phases; one kick runs one of them, or data then parity and spare
				if (kick) begin
					busy_nxt = 1'b1;
					cs_nxt = cs_sel;
					ecc_nxt = ecc_ena;
					rs_nxt = ecc_rs;
					page_nxt = page_size;
					spare_nxt = spare_size;
					byte_nxt = cmd_byte;
					cnt_nxt = '0;
					st_nxt = ST_WAIT;
					case (op)
						OP_CMD: begin
							ph_nxt = PH_CMD;
							wr_nxt = 1'b1;
						end
						OP_ADDR: begin
							ph_nxt = PH_ADDR;
							wr_nxt = 1'b1;
						end
						OP_PWRITE: begin
							ph_nxt = PH_DATA;
							wr_nxt = 1'b1;
						end
						// Re-kick reads the next page with no cmd/addr
						OP_PREAD: begin
							ph_nxt = PH_DATA;
							wr_nxt = 1'b0;
						end
						OP_DWRITE: begin
							ph_nxt = PH_DIRECT;
							wr_nxt = 1'b1;
						end
						default: begin
							ph_nxt = PH_DIRECT;
							wr_nxt = 1'b0;
						end
					endcase
				end
			end
			ST_WAIT: begin
				// Page bytes wait for a source byte or buffer room
				if (ph_r == PH_DATA && wr_r) begin
					if (tx_valid) begin
						dout_nxt = tx_data;
						st_nxt = ST_SETUP;
						tmr_nxt = t_setup;
					end
				end else if (ph_r == PH_DATA) begin
					if (rx_space) begin
						st_nxt = ST_SETUP;
						tmr_nxt = t_setup;
					end
				end else begin
					case (ph_r)
						PH_ECC: dout_nxt = calc_r[{cnt_r[2:0], 3'b000} +: 8];
						PH_SPARE: dout_nxt = PAD_BYTE;
						default: dout_nxt = byte_r;
					endcase
					st_nxt = ST_SETUP;
					tmr_nxt = t_setup;
				end
			end
			ST_SETUP: begin
				// Latch lines settle before the strobe falls
				if (tmr_r == '0) begin
					st_nxt = ST_PULSE;
					tmr_nxt = t_pulse;
				end else begin
					tmr_nxt = tmr_r - 1'b1;
				end
			end
			ST_PULSE: begin
				if (tmr_r == '0) begin
					st_nxt = ST_HOLD;
					tmr_nxt = t_hold;
					if (ph_r == PH_DIRECT && !wr_r) begin
						drd_nxt = nand_d_in;
					end
				end else begin
					tmr_nxt = tmr_r - 1'b1;
				end
			end
			ST_HOLD: begin
				if (tmr_r != '0) begin
					tmr_nxt = tmr_r - 1'b1;
				end else if (!last) begin
					cnt_nxt = cnt_r + 12'h001;
					st_nxt = ST_WAIT;
				end else begin
					// Data, then parity, then spare, each only if enabled
					cnt_nxt = '0;
					st_nxt = ST_WAIT;
					if (ph_r == PH_DATA && ecc_r) begin
						ph_nxt = PH_ECC;
					end else if ((ph_r == PH_DATA || ph_r == PH_ECC)
						&& spare_r != '0) begin
						ph_nxt = PH_SPARE;
					end else begin
						// No ready/busy pin: software waits on its own pin
						fin = 1'b1;
						st_nxt = ST_IDLE;
						busy_nxt = 1'b0;
						done_nxt = 1'b1;
					end
				end
			end
			default: begin
				st_nxt = ST_IDLE;
			end
		endcase
	end

	// ----------------------------------------
	// Parity next state
	// ----------------------------------------
	always_comb begin
		calc_nxt = calc_r;
		stored_nxt = stored_r;
		syn_nxt = syn_r;
		err_nxt = err_r;
		if (st_r == ST_IDLE && kick && op != OP_PREAD && op != OP_PWRITE) begin
			calc_nxt = calc_r;
		end else if (st_r == ST_IDLE && kick) begin
			calc_nxt = ECC_RST;
			stored_nxt = ECC_RST;
		end else if (strobe_end && ph_r == PH_DATA) begin
			// Parity follows each page byte as it crosses the bus
			calc_nxt = ecc_step(calc_r, wr_r ? dout_r : nand_d_in, cnt_r, rs_r);
		end else if (strobe_end && ph_r == PH_ECC && !wr_r) begin
			stored_nxt[{cnt_r[2:0], 3'b000} +: 8] = nand_d_in;
		end
		// Check result published as the read finishes
		if (fin && !wr_r && ecc_r) begin
			syn_nxt = calc_r ^ stored_r;
			err_nxt = (calc_r != stored_r);
		end
	end

	// ----------------------------------------
	// Registers, frozen while clk_en is low
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			st_r <= ST_IDLE;
			ph_r <= PH_CMD;
			tmr_r <= '0;
			cnt_r <= '0;
			wr_r <= 1'b0;
			busy_r <= 1'b0;
			done_r <= 1'b0;
			cs_r <= CS_RST;
			ecc_r <= 1'b0;
			rs_r <= 1'b0;
			page_r <= '0;
			spare_r <= '0;
			byte_r <= BYTE_RST;
			dout_r <= BYTE_RST;
			drd_r <= BYTE_RST;
			calc_r <= ECC_RST;
			stored_r <= ECC_RST;
			syn_r <= ECC_RST;
			err_r <= 1'b0;
		end else if (clk_en) begin
			st_r <= st_nxt;
			ph_r <= ph_nxt;
			tmr_r <= tmr_nxt;
			cnt_r <= cnt_nxt;
			wr_r <= wr_nxt;
			busy_r <= busy_nxt;
			done_r <= done_nxt;
			cs_r <= cs_nxt;
			ecc_r <= ecc_nxt;
			rs_r <= rs_nxt;
			page_r <= page_nxt;
			spare_r <= spare_nxt;
			byte_r <= byte_nxt;
			dout_r <= dout_nxt;
			drd_r <= drd_nxt;
			calc_r <= calc_nxt;
			stored_r <= stored_nxt;
			syn_r <= syn_nxt;
			err_r <= err_nxt;
		end
	end

	// ----------------------------------------
	// Flash pins
	// ----------------------------------------
	// Strobes are decoded from state flops, not registered on their own
	assign cle = busy_r && ph_r == PH_CMD && st_r != ST_WAIT;
	assign ale = busy_r && ph_r == PH_ADDR && st_r != ST_WAIT;
	assign wen_n = !(st_r == ST_PULSE && wr_r);
	assign ren_n = !(st_r == ST_PULSE && !wr_r);
	// Bus driven through setup, strobe and hold of a write only
	assign nand_d_oe = wr_r && (st_r == ST_SETUP || st_r == ST_PULSE
		|| st_r == ST_HOLD);
	assign nand_d_out = dout_r;
	// One-hot select; limitation: index only changes at a kick
	assign cen_n = (busy_r || cs_keep) ? ~(4'h1 << cs_r) : CEN_IDLE;
	assign busy = busy_r;
	assign done = done_r;
	assign ecc_err = err_r;
	assign ecc_syndrome = syn_r;
	assign dir_rdata = drd_r;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	chk_cs_one_hot: assert property (@(posedge ref_clk) disable iff (srst)
		$onehot0(~cen_n)) else $error("more than one chip selected");
	chk_latch_exclusive: assert property (@(posedge ref_clk) disable iff (srst)
		(cle || ale) |-> !(cle && ale) && ph_r != PH_DATA)
		else $error("latch enable outside its phase");
	chk_drive_write: assert property (@(posedge ref_clk) disable iff (srst)
		nand_d_oe |-> ren_n && wr_r) else $error("bus driven during read");
	chk_kick_busy: assert property (@(posedge ref_clk) disable iff (srst)
		(clk_en && kick && st_r == ST_IDLE) |=> busy && !done)
		else $error("kick did not raise busy");
	chk_done_ends: assert property (@(posedge ref_clk) disable iff (srst)
		$rose(done) |-> !busy && $past(busy))
		else $error("done without ending busy");
	chk_pulse_length: assert property (@(posedge ref_clk) disable iff (srst)
		(clk_en && strobe_end) |=> ren_n && wen_n)
		else $error("strobe longer than programmed");
	chk_parity_enabled: assert property (@(posedge ref_clk) disable iff (srst)
		(busy && ph_r == PH_ECC) |-> ecc_r) else $error("parity phase while off");
	chk_spare_discard: assert property (@(posedge ref_clk) disable iff (srst)
		(ph_r == PH_SPARE || ph_r == PH_ECC) |-> !rx_push)
		else $error("non-data byte pushed");
	chk_push_room: assert property (@(posedge ref_clk) disable iff (srst)
		rx_push |-> rx_space) else $error("push into full buffer");
	chk_parity_count: assert property (@(posedge ref_clk) disable iff (srst)
		(ph_r == PH_ECC) |-> cnt_r < ECC_BYTES) else $error("too many parity bytes");
endmodule

// ==== nand_flash_interface_ctrl_tb.sv ====
// Self-checking bench for the flash sequencer against the flash model.
`timescale 1ns/1ps
module nand_flash_interface_ctrl_tb
	import nand_ctrl_pkg::*;
;
	// ----
	// Signals
	// ----
	logic ref_clk, srst, clk_en, kick, cs_keep, ecc_ena, ecc_rs, busy, done, ecc_err;
	op_t op;
	logic [7:0] cmd_byte, dir_rdata, tx_data, rx_data, nand_d_in, nand_d_out, bus;
	logic [1:0] cs_sel;
	logic [11:0] page_size, spare_size;
	logic [3:0] t_setup, t_pulse, t_hold, cen_n, lcen;
	logic [47:0] ecc_syndrome;
	logic tx_valid, tx_ready, rx_valid, rx_ready, nand_d_oe, cle, ale, ren_n, wen_n;
	logic flip, lcle, lale, loe;
	logic [5:0] peek_idx;
	logic [7:0] peek, wr_ptr, rd_ptr, lbyte, lwidth;
	int num_errors, check_count, cyc;
	logic [7:0] txq [16]; // Page data to send
	logic [7:0] rxq [$]; // Page data received
	logic [7:0] par;
	typedef struct {op_t o; logic [7:0] b; logic [1:0] c; logic [3:0] s, p, h; logic ce, ae;} row_t;
	row_t rows [5] = '{'{OP_CMD, 8'h80, 2'h0, 4'h0, 4'h0, 4'h0, 1'b1, 1'b0},
		'{OP_ADDR, 8'h00, 2'h1, 4'h1, 4'h2, 4'h0, 1'b0, 1'b1},
		'{OP_ADDR, 8'h3C, 2'h2, 4'h0, 4'h3, 4'h1, 1'b0, 1'b1},
		'{OP_DWRITE, 8'h5A, 2'h3, 4'h2, 4'h1, 4'h2, 1'b0, 1'b0},
		'{OP_CMD, 8'h10, 2'h3, 4'h0, 4'h7, 4'h0, 1'b1, 1'b0}};
	// Bus level: the controller's drive wins while enabled, else the flash
	assign bus = nand_d_oe ? nand_d_out : nand_d_in;
	nand_flash_interface_ctrl dut_u (.ref_clk(ref_clk), .srst(srst), .clk_en(clk_en),
		.kick(kick), .op(op), .cmd_byte(cmd_byte), .cs_sel(cs_sel), .cs_keep(cs_keep),
		.page_size(page_size), .spare_size(spare_size), .ecc_ena(ecc_ena), .ecc_rs(ecc_rs),
		.t_setup(t_setup), .t_pulse(t_pulse), .t_hold(t_hold), .busy(busy), .done(done),
		.ecc_err(ecc_err), .ecc_syndrome(ecc_syndrome), .dir_rdata(dir_rdata),
		.tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
		.rx_valid(rx_valid), .rx_ready(rx_ready), .nand_d_in(nand_d_in),
		.nand_d_out(nand_d_out), .nand_d_oe(nand_d_oe), .cle(cle), .ale(ale),
		.cen_n(cen_n), .ren_n(ren_n), .wen_n(wen_n));
	nand_flash_model flash_u (.cle(cle), .ale(ale), .cen_n(cen_n), .ren_n(ren_n),
		.wen_n(wen_n), .d_out(bus), .d_oe(nand_d_oe), .flip(flip), .peek_idx(peek_idx),
		.d_drv(nand_d_in), .peek(peek), .wr_ptr(wr_ptr), .rd_ptr(rd_ptr), .last_byte(lbyte),
		.last_cle(lcle), .last_ale(lale), .last_oe(loe), .last_cen(lcen),
		.last_width(lwidth));
	// ----
	// Tasks
	// ----
	task automatic wrap_up();
		if (num_errors == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// A wait that used up its bound ends the run
	task automatic guard(input int k, input int lim);
		if (k >= lim) begin
			num_errors++;
			$display("Error at %0t: wait ran out", $time);
			wrap_up();
		end
	endtask
	task automatic start_op(input op_t o, input logic [7:0] b, input logic [1:0] c);
		@(negedge ref_clk);
		op = o;
		cmd_byte = b;
		cs_sel = c;
		kick = 1'b1;
		@(negedge ref_clk);
		kick = 1'b0;
		chk(busy, 1'b1);
	endtask
	task automatic wait_done();
		cyc = 0;
		while (done !== 1'b1 && cyc < 2000) begin
			@(negedge ref_clk);
			cyc++;
		end
		guard(cyc, 2000);
		chk(busy, 1'b0);
	endtask
	task automatic run(input op_t o, input logic [7:0] b, input logic [1:0] c);
		start_op(o, b, c);
		wait_done();
	endtask
	// Byte is offered until ready is seen high, then held across that rising edge
	task automatic feed(input int n);
		int k;
		@(negedge ref_clk);
		for (int i = 0; i < n; i++) begin
			tx_valid = 1'b1;
			tx_data = txq[i];
			k = 0;
			while (tx_ready !== 1'b1 && k < 500) begin
				@(negedge ref_clk);
				k++;
			end
			guard(k, 500);
			@(negedge ref_clk);
		end
		tx_valid = 1'b0;
	endtask
	// Receiver stalls first, so the buffer must hold what was read
	task automatic drain(input int want, input int stall);
		int k;
		k = 0;
		repeat (stall) @(negedge ref_clk);
		if (stall > 0) begin
			chk(rd_ptr, 8'h02);
		end
		rx_ready = 1'b1;
		// Settled outputs are taken mid-cycle; the next rising edge pops them
		while (rxq.size() < want && k < 3000) begin
			if (rx_valid === 1'b1) begin
				rxq.push_back(rx_data);
			end
			@(negedge ref_clk);
			k++;
		end
		guard(k, 3000);
	endtask
	task automatic page(input op_t o, input int n, input logic e, input logic r, input int sp,
		input int stall);
		page_size = 12'(n);
		spare_size = 12'(sp);
		ecc_ena = e;
		ecc_rs = r;
		rxq.delete();
		rx_ready = (stall == 0);
		fork
			run(o, 8'h00, 2'h1);
			if (o == OP_PWRITE) feed(n);
			drain((o == OP_PREAD) ? n : 0, stall);
		join
	endtask
	task automatic peek_chk(input logic [5:0] idx, input logic [7:0] exp);
		peek_idx = idx;
		#1;
		chk(peek, exp);
	endtask
	// ----
	// Stimulus
	// ----
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	initial begin
		{srst, clk_en, rx_ready} = 3'b111;
		{kick, cs_keep, ecc_ena, ecc_rs, tx_valid, flip} = 6'h00;
		op = OP_CMD;
		{cmd_byte, tx_data, cs_sel, peek_idx} = 24'h000000;
		{page_size, spare_size, t_setup, t_pulse, t_hold} = 36'h000000000;
		num_errors = 0;
		check_count = 0;
		par = 8'h00;
		for (int i = 0; i < 16; i++) begin
			txq[i] = 8'(i * 37 + 5);
		end
		repeat (8) @(negedge ref_clk);
		srst = 1'b0;
		chk({busy, done, cle, ale, ren_n, wen_n, nand_d_oe, rx_valid}, 8'h0C);
		chk(cen_n, 4'hF);
		// Single-byte phases, timing and chip choice per row
		foreach (rows[i]) begin
			{t_setup, t_pulse, t_hold} = {rows[i].s, rows[i].p, rows[i].h};
			run(rows[i].o, rows[i].b, rows[i].c);
			chk(lbyte, rows[i].b);
			chk({lcle, lale}, {rows[i].ce, rows[i].ae});
			chk(lcen, 4'(~(4'h1 << rows[i].c)));
			chk(lwidth, rows[i].p + 8'h01);
			chk(cyc, 4 + rows[i].s + rows[i].p + rows[i].h);
			chk(loe, 1'b1);
		end
		// Kick while busy is dropped, and so is its chip choice
		start_op(OP_CMD, 8'h70, 2'h1);
		start_op(OP_CMD, 8'hEE, 2'h2);
		chk(cen_n, 4'hD);
		wait_done();
		chk(lbyte, 8'h70);
		{t_setup, t_pulse, t_hold} = 12'h000;
		// Parity page written, read back with stall, spare skipped
		run(OP_CMD, 8'h80, 2'h1);
		page(OP_PWRITE, 8, 1'b1, 1'b0, 0, 0);
		for (int i = 0; i < 8; i++) begin
			par = par ^ txq[i];
		end
		chk(wr_ptr, 8'd14);
		peek_chk(6'd8, par);
		run(OP_CMD, 8'h00, 2'h1);
		page(OP_PREAD, 8, 1'b1, 1'b0, 3, 40);
		for (int i = 0; i < 8; i++) begin
			chk(rxq[i], txq[i]);
		end
		chk(rd_ptr, 8'd17);
		chk({ecc_err, ecc_syndrome}, 49'h0);
		// Next page by kick alone
		page(OP_PREAD, 8, 1'b1, 1'b0, 3, 0);
		for (int i = 0; i < 8; i++) begin
			chk(rxq[i], 8'(17 + i) ^ 8'hC3);
		end
		chk(rd_ptr, 8'd34);
		// One flipped bit must show in the check result
		run(OP_CMD, 8'h00, 2'h1);
		flip = 1'b1;
		page(OP_PREAD, 8, 1'b1, 1'b0, 0, 0);
		flip = 1'b0;
		chk(rxq[0], txq[0] ^ 8'h01);
		chk({ecc_err, ecc_syndrome[7:0]}, 9'h101);
		// Plain page, then symbol code page with pad bytes
		run(OP_CMD, 8'h80, 2'h1);
		page(OP_PWRITE, 4, 1'b0, 1'b0, 0, 0);
		chk(wr_ptr, 8'd4);
		run(OP_CMD, 8'h80, 2'h1);
		page(OP_PWRITE, 4, 1'b1, 1'b1, 2, 0);
		chk(wr_ptr, 8'd12);
		peek_chk(6'd10, 8'hFF);
		peek_chk(6'd11, 8'hFF);
		run(OP_CMD, 8'h00, 2'h1);
		page(OP_PREAD, 4, 1'b1, 1'b1, 0, 0);
		chk({ecc_err, ecc_syndrome}, 49'h0);
		// Frozen clock enable adds no cycles and loses no state
		start_op(OP_CMD, 8'h90, 2'h2);
		clk_en = 1'b0;
		repeat (5) @(negedge ref_clk);
		chk(busy, 1'b1);
		chk(cen_n, 4'hB);
		clk_en = 1'b1;
		wait_done();
		chk(cyc, 4);
		chk(lbyte, 8'h90);
		// Reset in mid-transfer, then a kick straight after release
		start_op(OP_ADDR, 8'h33, 2'h3);
		@(negedge ref_clk);
		srst = 1'b1;
		@(negedge ref_clk);
		chk({busy, done, cle, ale, ren_n, wen_n, nand_d_oe, rx_valid}, 8'h0C);
		chk(cen_n, 4'hF);
		srst = 1'b0;
		run(OP_CMD, 8'h5A, 2'h0);
		chk(lbyte, 8'h5A);
		chk(cyc, 4);
		chk(lcen, 4'hE);
		// Direct byte read and idle selection hold
		run(OP_CMD, 8'h00, 2'h1);
		run(OP_DREAD, 8'h00, 2'h1);
		chk(dir_rdata, txq[0]);
		cs_keep = 1'b1;
		@(negedge ref_clk);
		chk(cen_n, 4'hD);
		wrap_up();
	end
endmodule

// ==== nand_flash_model.sv ====
// Behavioural model of the external 8-bit flash part.
`timescale 1ns/1ps
module nand_flash_model #(
	parameter int CLK_NS = 10 // Clock period, sizes strobe widths
) (
	input wire logic cle,
	input wire logic ale,
	input wire logic [3:0] cen_n,
	input wire logic ren_n,
	input wire logic wen_n,
	input wire logic [7:0] d_out,
	input wire logic d_oe,
	input wire logic flip, // Corrupt bit 0 of the first byte read
	input wire logic [5:0] peek_idx,
	output logic [7:0] d_drv, // Level the flash puts on the bus
	output logic [7:0] peek,
	output logic [7:0] wr_ptr,
	output logic [7:0] rd_ptr,
	output logic [7:0] last_byte,
	output logic last_cle,
	output logic last_ale,
	output logic last_oe,
	output logic [3:0] last_cen,
	output logic [7:0] last_width
);
	// ----
	// Storage
	// ----
	logic [7:0] mem [0:63]; // Flat page array
	logic [7:0] cur; // Byte at the read pointer
	logic [7:0] rd_q; // Last byte handed out
	time t_fall; // Start of the running write strobe
	assign cur = mem[rd_ptr[5:0]] ^ {7'h00, flip && rd_ptr == 8'h00};
	// Released bus shows the inverse of the last byte, so stale data never matches
	assign d_drv = (!ren_n && cen_n != 4'hF) ? cur : ~rd_q;
	assign peek = mem[peek_idx];
	initial begin
		rd_q = 8'h00;
		wr_ptr = 8'h00;
		rd_ptr = 8'h00;
		t_fall = 0;
		for (int i = 0; i < 64; i++) begin
			mem[i] = 8'(i) ^ 8'hC3;
		end
	end
	// ----
	// Strobes
	// ----
	always @(negedge wen_n) begin
		t_fall = $time;
	end
	// Latch on the rising write strobe; deselected strobes are ignored
	always @(posedge wen_n) begin
		if (cen_n != 4'hF) begin
			last_byte = d_out;
			last_cle = cle;
			last_ale = ale;
			last_oe = d_oe;
			last_cen = cen_n;
			last_width = 8'(($time - t_fall) / CLK_NS);
			if (cle) begin
				// A command restarts both pointers
				wr_ptr = 8'h00;
				rd_ptr = 8'h00;
			end else if (!ale) begin
				mem[wr_ptr[5:0]] = d_out;
				wr_ptr = wr_ptr + 8'h01;
			end
		end
	end
	// Pointer runs on across kicks, so a further page needs no command
	always @(posedge ren_n) begin
		if (cen_n != 4'hF) begin
			rd_q = cur;
			rd_ptr = rd_ptr + 8'h01;
		end
	end
endmodule

// ==== rx_skid_buf.sv ====
// Small valid/ready buffer for received page bytes.
`timescale 1ns/1ps
module rx_skid_buf #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic clk_en,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
	logic [WIDTH-1:0] mem_r [DEPTH]; // Entry storage
	logic [WIDTH-1:0] mem_nxt [DEPTH];
	logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt; // Pointers
	logic [AW:0] cnt_r, cnt_nxt; // Fill level
	logic push, pop;
	// Honest flags: full blocks the writer, empty hides data
	assign in_ready = (cnt_r != FULL);
	assign out_valid = (cnt_r != '0);
	assign out_data = mem_r[rp_r];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		mem_nxt = mem_r;
		wp_nxt = wp_r;
		rp_nxt = rp_r;
		cnt_nxt = cnt_r;
		if (push) begin
			mem_nxt[wp_r] = in_data;
			wp_nxt = (wp_r == LAST) ? '0 : wp_r + 1'b1;
		end
		if (pop) begin
			rp_nxt = (rp_r == LAST) ? '0 : rp_r + 1'b1;
		end
		if (push && !pop) begin
			cnt_nxt = cnt_r + 1'b1;
		end else if (pop && !push) begin
			cnt_nxt = cnt_r - 1'b1;
		end
	end
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
			for (int i = 0; i < DEPTH; i++) begin
				mem_r[i] <= '0;
			end
		end else if (clk_en) begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			cnt_r <= cnt_nxt;
			mem_r <= mem_nxt;
		end
	end
endmodule
